// ===== dcq_engine.sv
// Transmit DMA engine: host command queue, 4K-aware burst subblocks, throttling.
// Assumes memory read data stand in the same cycle as mem_rd_r, and that the
// link interface and receiver flags are on clk_sys.
//
// What this block does
// - A burst subblock ends when the source or destination crosses a 4K byte page and the next one starts at the crossed address.
// - The last subblock of a command ends when its byte count reaches zero regardless of page position.
// - Page crossing works whether source and destination cross together or at different beats.
// - Subblock size is selectable as 8, 16 or 32 doublewords, and page or count ends may shorten any subblock.
// - The queue holds 128 waiting commands; a command taken by the engine frees its entry.
// - With link output held off the engine keeps taking commands and moving data until the transmit FIFO is half full.
// - A command written to a full queue sets the overflow flag and leaves queued commands intact.
// - Overflow also sets a halted flag that blocks all data movement even after output is re-enabled.
// - A completed-command index advances once per finished command and is readable.
// - The multiple grant request is raised while the transmit FIFO is half full.
// - After a transfer the source address counter holds the doubleword after the last one read.
// - Software may turn link output off and on; on re-enable buffered data and queued commands proceed.
// - Once the transmit FIFO is half full, memory reads stop at that beat and resume when space returns.
// - Memory reads also pause while the receive FIFO is half full.
// - Finishing a command raises a completion status with the index and sets a done flag in the byte count.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns
module dcq_engine
    import dcq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq_r,
    output logic mem_rd_r,
    output logic [29:0] mem_addr_r,
    input wire logic [31:0] mem_rdata,
    output logic tx_wr_r,
    output logic [31:0] tx_data_r,
    output logic [29:0] tx_dst_r,
    output logic tx_sub_last_r,
    input wire logic tx_half_full,
    input wire logic rx_half_full,
    output logic tx_out_en_r,
    output logic multi_grant_request_r
);
    // ************************************************************
    // Control registers
    // ************************************************************
    logic [2:0] ctrl_r;
    logic [1:0] int_status_r;
    logic [1:0] int_mask_r;
    logic [29:0] stage_src_r;
    logic [29:0] stage_dst_r;
    logic [31:0] rdata_r;
    logic queue_overflow_flag_r;
    logic transmit_halted_flag_r;
    logic [7:0] completed_command_index_r;
    logic done_r;

    logic push;
    logic pop;
    logic full;
    logic empty;
    logic overflow_evt;
    logic complete_evt;

    assign push = reg_wr && (reg_addr == DCQ_OFF_CMD_CNT) && !full;
    assign overflow_evt = reg_wr && (reg_addr == DCQ_OFF_CMD_CNT) && full;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_r <= DCQ_CTRL_RESET;
            int_mask_r <= DCQ_INT_RESET;
            stage_src_r <= '0;
            stage_dst_r <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                DCQ_OFF_CMD_SRC: stage_src_r <= reg_wdata[31:2];
                DCQ_OFF_CMD_DST: stage_dst_r <= reg_wdata[31:2];
                DCQ_OFF_CTRL: ctrl_r <= reg_wdata[2:0];
                DCQ_OFF_INT_MASK: int_mask_r <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Sticky events and interrupt
    // ************************************************************
    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            int_status_r <= DCQ_INT_RESET;
        end else begin
            int_status_r <= (int_status_r & ~((reg_wr && reg_addr == DCQ_OFF_INT_STATUS) ?
                reg_wdata[1:0] : 2'h0)) | {overflow_evt, complete_evt};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(int_status_r & int_mask_r);
        end
    end

    // halt holds until reset; relies on software doing that reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            queue_overflow_flag_r <= 1'b0;
            transmit_halted_flag_r <= 1'b0;
        end else if (overflow_evt) begin
            queue_overflow_flag_r <= 1'b1;
            transmit_halted_flag_r <= 1'b1;
        end
    end

    // output enable, forced off by halt
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_out_en_r <= 1'b0;
        end else begin
            tx_out_en_r <= ctrl_r[DCQ_CTRL_TXEN_BIT] && !transmit_halted_flag_r && !overflow_evt;
        end
    end

    // grant request follows FIFO half full
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            multi_grant_request_r <= 1'b0;
        end else begin
            multi_grant_request_r <= tx_half_full;
        end
    end

    // ************************************************************
    // Command queue
    // ************************************************************
    logic [29:0] q_src [DCQ_DEPTH];
    logic [29:0] q_dst [DCQ_DEPTH];
    logic [DCQ_DW_W-1:0] q_cnt [DCQ_DEPTH];
    logic [DCQ_PTR_W-1:0] wr_ptr_r;
    logic [DCQ_PTR_W-1:0] rd_ptr_r;
    logic [DCQ_PTR_W:0] used_r;

    assign full = (used_r == (DCQ_PTR_W+1)'(DCQ_DEPTH));
    assign empty = (used_r == '0);

    always_ff @(posedge clk_sys) begin
        if (push) begin
            q_src[wr_ptr_r] <= stage_src_r;
            q_dst[wr_ptr_r] <= stage_dst_r;
            q_cnt[wr_ptr_r] <= reg_wdata[DCQ_CNT_W-1:2];
        end
    end

    // entries freed as soon as the engine takes them
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            used_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + DCQ_PTR_W'(push);
            rd_ptr_r <= rd_ptr_r + DCQ_PTR_W'(pop);
            used_r <= used_r + (DCQ_PTR_W+1)'(push) - (DCQ_PTR_W+1)'(pop);
        end
    end

    // ************************************************************
    // Burst engine
    // ************************************************************
    dcq_state_t state_r;
    logic [29:0] source_address_counter_r;
    logic [29:0] dst_r;
    logic [DCQ_DW_W-1:0] left_r;
    logic [5:0] beat_r;
    logic [5:0] sub_beats;
    logic stall;
    logic beat;
    logic [29:0] src_next;
    logic [29:0] dst_next;
    logic sub_end;
    logic cmd_end;

    always_comb begin
        case (ctrl_r[DCQ_CTRL_SIZE_LSB +: 2])
            DCQ_SIZE_8: sub_beats = DCQ_BEATS_8;
            DCQ_SIZE_16: sub_beats = DCQ_BEATS_16;
            default: sub_beats = DCQ_BEATS_32;
        endcase
    end

    // data keeps moving with output held off; stop at half full
    assign stall = tx_half_full || rx_half_full || transmit_halted_flag_r;
    assign beat = (state_r == DCQ_S_BURST) && !stall;
    assign pop = (state_r == DCQ_S_IDLE) && !empty && !transmit_halted_flag_r;
    assign src_next = source_address_counter_r + 30'h1;
    assign dst_next = dst_r + 30'h1;
    assign cmd_end = (left_r == DCQ_DW_W'(1));
    // either page crossing ends the subblock; size limit
    assign sub_end = cmd_end || (src_next[DCQ_PAGE_LSB_W-1:0] == '0) ||
        (dst_next[DCQ_PAGE_LSB_W-1:0] == '0) || (beat_r + 6'h1 == sub_beats);
    assign complete_evt = (state_r == DCQ_S_DONE);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= DCQ_S_IDLE;
        end else begin
            case (state_r)
                DCQ_S_IDLE: begin
                    if (pop) begin
                        state_r <= (q_cnt[rd_ptr_r] == '0) ? DCQ_S_DONE : DCQ_S_BURST;
                    end
                end
                DCQ_S_BURST: begin
                    if (beat && sub_end) begin
                        state_r <= cmd_end ? DCQ_S_DONE : DCQ_S_SUBEND;
                    end
                end
                DCQ_S_SUBEND: state_r <= DCQ_S_BURST;
                DCQ_S_DONE: state_r <= DCQ_S_IDLE;
                default: state_r <= DCQ_S_IDLE;
            endcase
        end
    end

    // counter advances per read, so it ends one past the last
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            source_address_counter_r <= '0;
            dst_r <= '0;
            left_r <= '0;
        end else if (pop) begin
            source_address_counter_r <= q_src[rd_ptr_r];
            dst_r <= q_dst[rd_ptr_r];
            left_r <= q_cnt[rd_ptr_r];
        end else if (beat) begin
            source_address_counter_r <= src_next;
            dst_r <= dst_next;
            left_r <= left_r - DCQ_DW_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            beat_r <= '0;
        end else if (state_r != DCQ_S_BURST) begin
            beat_r <= '0;
        end else if (beat) begin
            beat_r <= beat_r + 6'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            completed_command_index_r <= '0;
            done_r <= 1'b0;
        end else if (complete_evt) begin
            completed_command_index_r <= completed_command_index_r + 8'h1;
            done_r <= 1'b1;
        end else if (pop) begin
            done_r <= 1'b0;
        end
    end

    // ************************************************************
    // Memory read and transmit path
    // ************************************************************
    logic sub_last_d_r;
    logic [29:0] dst_d_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_rd_r <= 1'b0;
            mem_addr_r <= '0;
            sub_last_d_r <= 1'b0;
            dst_d_r <= '0;
        end else begin
            mem_rd_r <= beat;
            mem_addr_r <= source_address_counter_r;
            sub_last_d_r <= beat && sub_end;
            dst_d_r <= dst_r;
        end
    end

    // Data stand beside mem_rd_r and are captured at its end, keeping outputs on flops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_wr_r <= 1'b0;
            tx_data_r <= '0;
            tx_dst_r <= '0;
            tx_sub_last_r <= 1'b0;
        end else begin
            tx_wr_r <= mem_rd_r;
            tx_data_r <= mem_rdata;
            tx_dst_r <= dst_d_r;
            tx_sub_last_r <= mem_rd_r && sub_last_d_r;
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                DCQ_OFF_CMD_SRC: rdata_r <= {stage_src_r, 2'h0};
                DCQ_OFF_CMD_DST: rdata_r <= {stage_dst_r, 2'h0};
                DCQ_OFF_CTRL: rdata_r <= {29'h0, ctrl_r};
                DCQ_OFF_STATUS: rdata_r <= {16'h0, completed_command_index_r, 4'h0,
                    state_r != DCQ_S_IDLE, transmit_halted_flag_r, queue_overflow_flag_r, full};
                DCQ_OFF_INT_STATUS: rdata_r <= {16'h0, completed_command_index_r, 6'h0,
                    int_status_r};
                DCQ_OFF_INT_MASK: rdata_r <= {30'h0, int_mask_r};
                DCQ_OFF_SRC_ADDR: rdata_r <= {source_address_counter_r, 2'h0};
                DCQ_OFF_BYTE_CNT: rdata_r <= {done_r, 11'h0, left_r, 2'h0};
                default: rdata_r <= '0;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end
    assign reg_rdata = rdata_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_full_write;
        reg_wr && reg_addr == DCQ_OFF_CMD_CNT && full;
    endsequence

    sequence s_last_beat;
        beat && cmd_end;
    endsequence

    a_page_split: assert property (@(posedge clk_sys) disable iff (rst)
        beat && (src_next[9:0] == 10'h0) |=> state_r != DCQ_S_BURST || beat_r == 6'h0)
        else $error("burst ran over a source page");
    a_dual_cross: assert property (@(posedge clk_sys) disable iff (rst)
        beat && (dst_next[9:0] == 10'h0) |=> state_r != DCQ_S_BURST)
        else $error("destination crossing missed");
    a_count_end: assert property (@(posedge clk_sys) disable iff (rst)
        s_last_beat |=> state_r == DCQ_S_DONE ##1 state_r == DCQ_S_IDLE)
        else $error("command did not end at zero count");
    a_size_limit: assert property (@(posedge clk_sys) disable iff (rst)
        beat |-> beat_r < sub_beats)
        else $error("subblock exceeded size");
    a_queue_keep: assert property (@(posedge clk_sys) disable iff (rst)
        s_full_write |=> used_r == $past(used_r) - 8'($past(pop)) && queue_overflow_flag_r)
        else $error("overflow write changed queue");
    a_halt_stop: assert property (@(posedge clk_sys) disable iff (rst)
        s_full_write |=> ##1 (!beat && !pop && !tx_out_en_r) [*8])
        else $error("data moved while halted");
    a_index_step: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == DCQ_S_DONE |=> completed_command_index_r == $past(completed_command_index_r) + 8'h1)
        else $error("index did not advance");
    a_grant_req: assert property (@(posedge clk_sys) disable iff (rst)
        tx_half_full |=> multi_grant_request_r)
        else $error("grant request missing");
    a_throttle: assert property (@(posedge clk_sys) disable iff (rst)
        tx_half_full || rx_half_full |=> !mem_rd_r)
        else $error("memory read while throttled");
    a_sa_next: assert property (@(posedge clk_sys) disable iff (rst)
        beat |=> source_address_counter_r == $past(source_address_counter_r) + 30'h1)
        else $error("source counter not bumped");
    a_push_take: assert property (@(posedge clk_sys) disable iff (rst)
        push && !pop |=> used_r == $past(used_r) + 8'h1)
        else $error("command write dropped");
    a_done_flag: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == DCQ_S_DONE |=> done_r && int_status_r[DCQ_INT_CMPLT_BIT])
        else $error("completion not reported");
endmodule // dcq_engine

// ===== dcq_far_model.sv
// Far side of the engine: onboard memory and the transmit FIFO toward the link.
// Assumes one clk_sys domain; memory answers in the cycle of each read pulse.
`timescale 1ns/1ns
module dcq_far_model #(
    parameter int HALF = 288
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mem_rd_r,
    input wire logic [29:0] mem_addr_r,
    output logic [31:0] mem_rdata,
    input wire logic tx_wr_r,
    input wire logic tx_out_en_r,
    output logic tx_half_full,
    output int level
);
    // ************************************************************
    // Memory
    // ************************************************************
    // Word equals its dword address while read is high; otherwise the inverse,
    // so a capture taken a cycle off never matches
    assign mem_rdata = mem_rd_r ? {2'h0, mem_addr_r} : ~{2'h0, mem_addr_r};

    // ************************************************************
    // Transmit FIFO
    // ************************************************************
    // drains only while enabled
    always @(posedge clk_sys) begin
        if (rst) begin
            level <= 0;
        end else begin
            level <= level + (tx_wr_r ? 1 : 0) - ((tx_out_en_r && level > 0) ? 1 : 0);
        end
    end
    assign tx_half_full = (level >= HALF);
endmodule // dcq_far_model

// ===== dcq_pkg.sv
// Constants shared by the transmit DMA command queue and its register port.
// Assumes a 32-bit plain register port with byte offsets, one word per register.
package dcq_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] DCQ_OFF_CMD_SRC = 8'h00;
    localparam logic [7:0] DCQ_OFF_CMD_DST = 8'h04;
    localparam logic [7:0] DCQ_OFF_CMD_CNT = 8'h08;
    localparam logic [7:0] DCQ_OFF_CTRL = 8'h0C;
    localparam logic [7:0] DCQ_OFF_STATUS = 8'h10;
    localparam logic [7:0] DCQ_OFF_INT_STATUS = 8'h14;
    localparam logic [7:0] DCQ_OFF_INT_MASK = 8'h18;
    localparam logic [7:0] DCQ_OFF_SRC_ADDR = 8'h1C;
    localparam logic [7:0] DCQ_OFF_BYTE_CNT = 8'h20;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int DCQ_CTRL_TXEN_BIT = 0;
    localparam int DCQ_CTRL_SIZE_LSB = 1;
    localparam int DCQ_ST_FULL_BIT = 0;
    localparam int DCQ_ST_OVFL_BIT = 1;
    localparam int DCQ_ST_HALT_BIT = 2;
    localparam int DCQ_ST_BUSY_BIT = 3;
    localparam int DCQ_ST_INDEX_LSB = 8;
    localparam int DCQ_INT_CMPLT_BIT = 0;
    localparam int DCQ_INT_OVFL_BIT = 1;
    localparam int DCQ_BC_DONE_BIT = 31;
    localparam logic [2:0] DCQ_CTRL_RESET = 3'h0;
    localparam logic [1:0] DCQ_INT_RESET = 2'h0;

    // ************************************************************
    // Sizes and counts
    // ************************************************************
    localparam int DCQ_DEPTH = 128;
    localparam int DCQ_PTR_W = 7;
    localparam int DCQ_CNT_W = 20;
    localparam int DCQ_DW_W = DCQ_CNT_W - 2;
    localparam int DCQ_PAGE_LSB_W = 10;
    localparam logic [1:0] DCQ_SIZE_8 = 2'h0;
    localparam logic [1:0] DCQ_SIZE_16 = 2'h1;
    localparam logic [5:0] DCQ_BEATS_8 = 6'h08;
    localparam logic [5:0] DCQ_BEATS_16 = 6'h10;
    localparam logic [5:0] DCQ_BEATS_32 = 6'h20;

    typedef enum logic [1:0] {
        DCQ_S_IDLE = 2'b00,
        DCQ_S_BURST = 2'b01,
        DCQ_S_SUBEND = 2'b11,
        DCQ_S_DONE = 2'b10
    } dcq_state_t;
endpackage

// ===== tb_dma_command_queue_boundary_split.sv
// Self-checking bench for the command queue engine and its register port.
// Assumes the far-side model for memory and transmit FIFO on the same clock.
`timescale 1ns/1ns
module tb_dma_command_queue_boundary_split;
    import dcq_pkg::*;
    logic clk_sys, rst, reg_wr, reg_rd, rx_half_full, irq_r, mem_rd_r, tx_wr_r;
    logic tx_sub_last_r, tx_half_full, tx_out_en_r, multi_grant_request_r;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_rdata, tx_data_r, v;
    logic [29:0] mem_addr_r, tx_dst_r, tx_dst_off;
    int level, err_total, tests_run, cyc, rd_total, wr_total, sub_len, word_err, w, c;
    int q_len[$];

    dcq_engine dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_r(irq_r),
        .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r), .mem_rdata(mem_rdata),
        .tx_wr_r(tx_wr_r), .tx_data_r(tx_data_r), .tx_dst_r(tx_dst_r),
        .tx_sub_last_r(tx_sub_last_r), .tx_half_full(tx_half_full),
        .rx_half_full(rx_half_full), .tx_out_en_r(tx_out_en_r),
        .multi_grant_request_r(multi_grant_request_r));
    dcq_far_model far (.clk_sys(clk_sys), .rst(rst), .mem_rd_r(mem_rd_r),
        .mem_addr_r(mem_addr_r), .mem_rdata(mem_rdata), .tx_wr_r(tx_wr_r),
        .tx_out_en_r(tx_out_en_r), .tx_half_full(tx_half_full), .level(level));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ************************************************************
    // Monitor and timeout
    // ************************************************************
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (mem_rd_r === 1'b1) rd_total <= rd_total + 1;
        if (tx_wr_r === 1'b1) begin
            wr_total <= wr_total + 1;
            if (tx_data_r[31:30] !== 2'h0 || tx_dst_r - tx_data_r[29:0] !== tx_dst_off)
                word_err <= word_err + 1;
            if (tx_sub_last_r === 1'b1) begin
                q_len.push_back(sub_len + 1);
                sub_len <= 0;
            end else begin
                sub_len <= sub_len + 1;
            end
        end
        if (cyc >= 60000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic idle(int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk_sys);
    endtask

    task automatic cmd(logic [31:0] s, logic [31:0] d, logic [31:0] n);
        wr(DCQ_OFF_CMD_SRC, s);
        wr(DCQ_OFF_CMD_DST, d);
        wr(DCQ_OFF_CMD_CNT, n);
    endtask

    task automatic wait_idx(logic [7:0] n);
        idle(1);
        rd(DCQ_OFF_STATUS);
        for (int i = 0; i < 12000 && v[15:8] !== n; i++) rd(DCQ_OFF_STATUS);
        check("index", v[15:8], n);
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        idle(12);
        rst <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    function automatic int split_code();
        int s = 0;
        foreach (q_len[i]) s = s * 100 + q_len[i];
        return s;
    endfunction

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {reg_wr, reg_rd, rx_half_full, reg_addr, reg_wdata, tx_dst_off} = '0;
        {err_total, tests_run, cyc, rd_total, wr_total, sub_len, word_err} = '0;
        do_reset();
        rd(DCQ_OFF_STATUS);
        check("status reset", v, 32'h0);
        rd(DCQ_OFF_CTRL);
        check("ctrl reset", v, 32'h0);
        rd(DCQ_OFF_INT_STATUS);
        check("int reset", v, 32'h0);
        rd(8'h24);
        check("unmapped", v, 32'h0);
        wr(DCQ_OFF_INT_MASK, 32'h3);
        // Source crosses then destination, both together, then full-size subblocks
        for (int sz = 0; sz < 3; sz++) begin
            wr(DCQ_OFF_CTRL, (sz << 1) | 1);
            q_len.delete();
            tx_dst_off = 30'h3FF;
            cmd(32'h0FFC, 32'h1FF8, 32'h1C);
            wait_idx(3 * sz + 1);
            check("split 1-1-5", split_code(), 10105);
            rd(DCQ_OFF_SRC_ADDR);
            check("src counter", v, 32'h1018);
            rd(DCQ_OFF_BYTE_CNT);
            check("byte count done", v, 32'h8000_0000);
            q_len.delete();
            tx_dst_off = 30'h400;
            cmd(32'h0FF0, 32'h1FF0, 32'h1C);
            wait_idx(3 * sz + 2);
            check("split 4-3", split_code(), 403);
            q_len.delete();
            tx_dst_off = 30'h1000;
            rx_half_full <= (sz == 2);
            w = rd_total;
            cmd(32'h2000, 32'h6000, 32'h80);
            idle(50);
            check("rx stall", rd_total - w, (sz == 2) ? 0 : 32);
            rx_half_full <= 1'b0;
            wait_idx(3 * sz + 3);
            c = 0;
            for (int k = 0; k < 32 / (8 << sz); k++) c = c * 100 + (8 << sz);
            check("split size", split_code(), c);
        end
        idle(3);
        check("irq set", irq_r, 1'b1);
        rd(DCQ_OFF_INT_STATUS);
        check("int status", v & 32'hFF03, 32'h0901);
        wr(DCQ_OFF_INT_MASK, 32'h0);
        idle(3);
        check("irq masked", irq_r, 1'b0);
        wr(DCQ_OFF_INT_MASK, 32'h1);
        wr(DCQ_OFF_INT_STATUS, 32'h1);
        idle(3);
        check("irq cleared", irq_r, 1'b0);
        check("word pattern", word_err, 0);
        // 133 commands fill the 128-entry queue with output off, then drain on enable
        do_reset();
        wr(DCQ_OFF_CTRL, 32'h4);
        tx_dst_off = 30'hC000;
        w = wr_total;
        for (int k = 0; k < 133; k++) cmd(32'h10000 + k * 256, 32'h40000 + k * 256, 256);
        idle(60);
        rd(DCQ_OFF_STATUS);
        check("queue full", v & ~32'h8, 32'h0401);
        check("half stop", level >= 288 && level <= 292, 1'b1);
        check("multi grant", multi_grant_request_r, 1'b1);
        c = rd_total;
        idle(10);
        check("reads frozen", rd_total, c);
        wr(DCQ_OFF_CTRL, 32'h5);
        wait_idx(133);
        rd(DCQ_OFF_SRC_ADDR);
        check("src after queue", v, 32'h18500);
        check("words moved", wr_total - w, 8512);
        check("word pattern", word_err, 0);
        // Overflow on the 134th command halts all movement
        do_reset();
        wr(DCQ_OFF_CTRL, 32'h4);
        for (int k = 0; k < 134; k++) cmd(32'h10000 + k * 256, 32'h40000 + k * 256, 256);
        idle(60);
        rd(DCQ_OFF_STATUS);
        check("overflow status", v & ~32'h8, 32'h0407);
        rd(DCQ_OFF_INT_STATUS);
        check("overflow int", v[1], 1'b1);
        w = wr_total;
        wr(DCQ_OFF_CTRL, 32'h5);
        idle(100);
        check("halted no data", wr_total, w);
        check("halted output", tx_out_en_r, 1'b0);
        do_reset();
        rd(DCQ_OFF_STATUS);
        check("status cleared", v, 32'h0);
        tally_and_finish();
    end
endmodule // tb_dma_command_queue_boundary_split
